/* design/oled_power_init_sequencer.v */
// host-side power-up and power-down sequencer for the display module
//
// Local design decisions: the address map and the APB register port.
`include "oled_seq_consts.vh"

// Summary of operation
// R1 - hold converter enable low after logic supply
// R2 - pulse module reset low over 100us
// R3 - wait 1ms after reset release
// R4 - send unlock FD 12 then display off
// R5 - send clock divide D5 70
// R6 - send multiplex ratio A8 3F
// R7 - send display offset D3 00
// R8 - send start line 40
// R9 - send page addressing 20 02
// R10 - send column remap A0
// R11 - send row scan direction C0
// R12 - send row pin config DA 12
// R13 - send contrast 81 CF
// R14 - send precharge D9 82
// R15 - send deselect level DB 3C
// R16 - send display from memory A4
// R17 - send normal polarity A6, clear
// R18 - raise converter enable, then display on AF; the enable stays low while bypass is set
// R19 - wait 100ms after display on
// R20 - power down: off, converter low, wait
// R21 - software may restart to refresh state
// R22 - clear all eight pages with addressing
// R23 - done only after final wait, restartable
module oled_power_init_sequencer #(
    parameter RESET_LOW_CYC  = `RESET_LOW_CYC,
    parameter RESET_WAIT_CYC = `RESET_WAIT_CYC,
    parameter ON_WAIT_CYC    = `ON_WAIT_CYC,
    parameter OFF_WAIT_CYC   = `OFF_WAIT_CYC
) (
    // clock and reset
    input  wire        clock,
    input  wire        rstn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // module pins
    output reg         converterEnableN,
    output reg         moduleClearN,
    // byte stream to the command interface
    output reg  [7:0]  cmdByte,
    output reg         cmdIsData,
    output reg         cmdValid,
    input  wire        cmdReady,
    // status
    output reg         done
);
    // one-hot sequencer states
    localparam S_IDLE  = 9'h001;
    localparam S_RLOW  = 9'h002;
    localparam S_RWAIT = 9'h004;
    localparam S_INIT  = 9'h008;
    localparam S_CLEAR = 9'h010;
    localparam S_ON    = 9'h020;
    localparam S_OWAIT = 9'h040;
    localparam S_DOWN  = 9'h080;
    localparam S_DWAIT = 9'h100;

    reg  [8:0]  state_reg;
    reg  [31:0] count_reg;
    reg  [5:0]  idx_reg;
    reg  [3:0]  page_reg;
    reg  [7:0]  col_reg;
    reg  [1:0]  hdr_reg;
    reg         bypass_reg;
    reg         startReq_reg;
    reg         offReq_reg;
    reg         off_reg;

    // next values of the sequencer registers
    reg  [8:0]  state_next;
    reg  [31:0] count_next;
    reg  [5:0]  idx_next;
    reg  [3:0]  page_next;
    reg  [7:0]  col_next;
    reg  [1:0]  hdr_next;
    reg         off_next;
    reg         converterEnableN_next;
    reg         moduleClearN_next;
    reg  [7:0]  cmdByte_next;
    reg         cmdIsData_next;
    reg         cmdValid_next;
    reg         done_next;

    wire        apbWr = psel & penable & pwrite & ~pready;
    wire        apbRd = psel & penable & ~pwrite & ~pready;
    wire        sent  = cmdValid & cmdReady;
    wire        slotFree = ~cmdValid | sent;
    wire        busy  = (state_reg != S_IDLE) & (state_reg != S_OWAIT)
                        | (state_reg == S_OWAIT & ~done);

    function [7:0] initByte;
        input [5:0] i;
        begin
            // fixed configuration bytes, sent in this order
            case (i)
                6'd0:  initByte = 8'hFD; // see R4
                6'd1:  initByte = 8'h12;
                6'd2:  initByte = `CMD_OFF;
                6'd3:  initByte = 8'hD5; // see R5
                6'd4:  initByte = 8'h70;
                6'd5:  initByte = 8'hA8; // see R6
                6'd6:  initByte = 8'h3F;
                6'd7:  initByte = 8'hD3; // see R7
                6'd8:  initByte = 8'h00;
                6'd9:  initByte = 8'h40; // see R8
                6'd10: initByte = 8'h20; // see R9
                6'd11: initByte = 8'h02;
                6'd12: initByte = 8'hA0; // see R10
                6'd13: initByte = 8'hC0; // see R11
                6'd14: initByte = 8'hDA; // see R12
                6'd15: initByte = 8'h12;
                6'd16: initByte = 8'h81; // see R13
                6'd17: initByte = 8'hCF;
                6'd18: initByte = 8'hD9; // see R14
                6'd19: initByte = 8'h82;
                6'd20: initByte = 8'hDB; // see R15
                6'd21: initByte = 8'h3C;
                6'd22: initByte = 8'hA4; // see R16
                6'd23: initByte = 8'hA6; // see R17
                default: initByte = 8'h00;
            endcase
        end
    endfunction

    // counters run down to zero and rest there
    function isZero;
        input [31:0] c;
        begin
            isZero = (c == 32'h00000000);
        end
    endfunction

    function [31:0] countDown;
        input [31:0] c;
        begin
            countDown = c - 32'h00000001;
        end
    endfunction

    // apb slave: one wait state in the access phase, pready for a single cycle
    always @(posedge clock) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (apbWr && paddr != `REG_CTRL && paddr != `REG_STAT)
                pslverr <= 1'b1;
            if (apbRd) begin
                case (paddr)
                    `REG_CTRL: prdata <= {29'h00000000, bypass_reg,
                                          2'b00};
                    `REG_STAT: prdata <= {20'h00000, off_reg, busy,
                                          done, state_reg};
                    default: begin
                        prdata  <= 32'h00000000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // control register; requests are one-shot
    always @(posedge clock) begin
        if (!rstn) begin
            bypass_reg   <= 1'b0;
            startReq_reg <= 1'b0;
            offReq_reg   <= 1'b0;
        end else begin
            // consumed once the sequencer has left idle and wait
            if (state_reg != S_IDLE && state_reg != S_OWAIT) begin
                startReq_reg <= 1'b0;
                offReq_reg   <= 1'b0;
            end
            // a write in the same cycle wins over the consumption
            if (apbWr && paddr == `REG_CTRL) begin
                bypass_reg <= pwdata[`BIT_BYPASS];
                if (pwdata[`BIT_START])
                    startReq_reg <= 1'b1; // see R21
                if (pwdata[`BIT_OFF])
                    offReq_reg <= 1'b1;
            end
        end
    end

    // sequencer: next values worked out here, registered below
    always @* begin
        // hold everything unless a state below moves it
        state_next            = state_reg;
        count_next            = count_reg;
        idx_next              = idx_reg;
        page_next             = page_reg;
        col_next              = col_reg;
        hdr_next              = hdr_reg;
        off_next              = off_reg;
        converterEnableN_next = converterEnableN;
        moduleClearN_next     = moduleClearN;
        cmdByte_next          = cmdByte;
        cmdIsData_next        = cmdIsData;
        cmdValid_next         = cmdValid;
        done_next             = done;

        // a byte leaves the stream once it is taken
        if (sent)
            cmdValid_next = 1'b0;

        case (state_reg)
            S_IDLE, S_OWAIT: begin
                // the wait runs from acceptance of display-on
                if (state_reg == S_OWAIT && !done && !cmdValid) begin
                    if (isZero(count_reg))
                        done_next = 1'b1; // see R19, R23
                    else
                        count_next = countDown(count_reg);
                end
                // a pending byte is never withdrawn, so requests wait
                if (startReq_reg && !cmdValid) begin
                    // full restart from reset; converter off first
                    done_next             = 1'b0;
                    off_next              = 1'b0;
                    converterEnableN_next = 1'b0; // see R1
                    moduleClearN_next     = 1'b0; // see R2
                    count_next            = RESET_LOW_CYC;
                    state_next            = S_RLOW;
                end else if (offReq_reg && !off_reg && !cmdValid) begin
                    done_next      = 1'b0;
                    cmdByte_next   = `CMD_OFF; // see R20
                    cmdIsData_next = 1'b0;
                    cmdValid_next  = 1'b1;
                    state_next     = S_DOWN;
                end
            end

            S_RLOW: begin
                if (isZero(count_reg)) begin
                    moduleClearN_next = 1'b1; // see R2
                    count_next        = RESET_WAIT_CYC;
                    state_next        = S_RWAIT;
                end else
                    count_next = countDown(count_reg);
            end

            S_RWAIT: begin
                if (isZero(count_reg)) begin // see R3
                    idx_next   = 6'h00;
                    state_next = S_INIT;
                end else
                    count_next = countDown(count_reg);
            end

            S_INIT: begin
                if (slotFree) begin
                    if (idx_reg == `INIT_LEN - 6'd1) begin
                        page_next  = 4'h0;
                        col_next   = 8'h00;
                        hdr_next   = 2'h0;
                        state_next = S_CLEAR;
                    end else begin
                        cmdByte_next   = initByte(idx_reg); // see R4
                        cmdIsData_next = 1'b0;
                        cmdValid_next  = 1'b1;
                        idx_next       = idx_reg + 6'd1;
                    end
                end
            end

            S_CLEAR: begin
                if (slotFree) begin
                    cmdValid_next = 1'b1;
                    if (hdr_reg != 2'h3) begin
                        // page, column low, column high before data
                        cmdIsData_next = 1'b0; // see R22
                        case (hdr_reg)
                            2'h0: cmdByte_next = `CMD_PAGE |
                                                 {4'h0, page_reg};
                            2'h1: cmdByte_next = `CMD_COL_LO;
                            default: cmdByte_next = `CMD_COL_HI;
                        endcase
                        hdr_next = hdr_reg + 2'h1;
                    end else begin
                        cmdIsData_next = 1'b1;
                        cmdByte_next   = 8'h00;
                        if (col_reg == `CLR_COLS - 8'd1) begin
                            col_next = 8'h00;
                            hdr_next = 2'h0;
                            if (page_reg == `CLR_PAGES - 4'd1)
                                state_next = S_ON;
                            else
                                page_next = page_reg + 4'h1;
                        end else
                            col_next = col_reg + 8'd1;
                    end
                end
            end

            S_ON: begin
                if (!cmdValid) begin
                    // converter up only once clearing has gone out;
                    // an open bypass jumper leaves it shut down
                    converterEnableN_next = ~bypass_reg; // see R18
                    cmdByte_next          = `CMD_ON; // see R18
                    cmdIsData_next        = 1'b0;
                    cmdValid_next         = 1'b1;
                    count_next            = ON_WAIT_CYC;
                    state_next            = S_OWAIT;
                end
            end

            S_DOWN: begin
                if (sent) begin
                    converterEnableN_next = 1'b0; // see R20
                    count_next            = OFF_WAIT_CYC;
                    state_next            = S_DWAIT;
                end
            end

            S_DWAIT: begin
                if (isZero(count_reg)) begin // see R20
                    off_next   = 1'b1;
                    state_next = S_IDLE;
                end else
                    count_next = countDown(count_reg);
            end

            default: state_next = S_IDLE;
        endcase
    end

    // sequencer registers; reset leaves the converter shut down
    always @(posedge clock) begin
        if (!rstn) begin
            state_reg        <= S_IDLE;
            count_reg        <= 32'h00000000;
            idx_reg          <= 6'h00;
            page_reg         <= 4'h0;
            col_reg          <= 8'h00;
            hdr_reg          <= 2'h0;
            off_reg          <= 1'b1;
            converterEnableN <= 1'b0; // see R1
            moduleClearN     <= 1'b1;
            cmdByte          <= 8'h00;
            cmdIsData        <= 1'b0;
            cmdValid         <= 1'b0;
            done             <= 1'b0;
        end else begin
            state_reg        <= state_next;
            count_reg        <= count_next;
            idx_reg          <= idx_next;
            page_reg         <= page_next;
            col_reg          <= col_next;
            hdr_reg          <= hdr_next;
            off_reg          <= off_next;
            converterEnableN <= converterEnableN_next;
            moduleClearN     <= moduleClearN_next;
            cmdByte          <= cmdByte_next;
            cmdIsData        <= cmdIsData_next;
            cmdValid         <= cmdValid_next;
            done             <= done_next;
        end
    end
endmodule // oled_power_init_sequencer

/* design/oled_seq_consts.vh */
// constants for the display power sequencer
`ifndef OLED_SEQ_CONSTS_VH
`define OLED_SEQ_CONSTS_VH
`define CLK_MHZ        100
`define RESET_LOW_US   100
`define RESET_LOW_CYC  ((`RESET_LOW_US * `CLK_MHZ) + 1)
`define RESET_WAIT_US  1000
`define RESET_WAIT_CYC (`RESET_WAIT_US * `CLK_MHZ)
`define ON_WAIT_MS     100
`define ON_WAIT_CYC    (`ON_WAIT_MS * 1000 * `CLK_MHZ)
`define OFF_WAIT_MS    100
`define OFF_WAIT_CYC   (`OFF_WAIT_MS * 1000 * `CLK_MHZ)
`define INIT_LEN       6'd25
`define CLR_PAGES      4'd8
`define CLR_COLS       8'd128
`define CMD_OFF        8'hAE
`define CMD_ON         8'hAF
`define CMD_PAGE       8'hB0
`define CMD_COL_LO     8'h00
`define CMD_COL_HI     8'h10
`define REG_CTRL       8'h00
`define REG_STAT       8'h04
`define BIT_START      0
`define BIT_OFF        1
`define BIT_BYPASS     2
`endif

/* verification/oled_module_model.sv */
// display module model: takes the command stream and logs it
module oled_module_model (
    input wire       clock,
    input wire       moduleClearN,
    input wire       converterEnableN,
    input wire [7:0] cmdByte,
    input wire       cmdIsData,
    input wire       cmdValid,
    input wire       stall,
    output logic     cmdReady
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] got[$];
    logic prevFd = 0, unlocked = 0, fromMemory = 0, convAtOn = 0;
    initial cmdReady = 0;
    // ready is registered, so a stall costs at least one whole cycle
    always @(posedge clock) begin
        cmdReady <= !stall;
        if (!moduleClearN) begin
            unlocked <= 0;
            fromMemory <= 0;
        end else if (cmdValid && cmdReady) begin
            got.push_back({cmdIsData, cmdByte});
            prevFd <= !cmdIsData && cmdByte == 8'hFD;
            if (prevFd && !cmdIsData && cmdByte == 8'h12)
                unlocked <= 1;
            if (unlocked && !cmdIsData && cmdByte == 8'hA4)
                fromMemory <= 1;
            if (!cmdIsData && cmdByte == 8'hAF)
                convAtOn <= converterEnableN; // pin high: converter runs
        end
    end
endmodule // oled_module_model

/* verification/oled_power_init_sequencer_tb.sv */
// self-checking bench for the display power sequencer
module oled_power_init_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] INIT [24] = '{8'hFD, 8'h12, 8'hAE, 8'hD5,
        8'h70, 8'hA8, 8'h3F, 8'hD3, 8'h00, 8'h40, 8'h20, 8'h02, 8'hA0,
        8'hC0, 8'hDA, 8'h12, 8'h81, 8'hCF, 8'hD9, 8'h82, 8'hDB, 8'h3C,
        8'hA4, 8'hA6};
    logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic stall = 0, slow = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, lfsr = 32'h05AD236F;
    logic [8:0] exp[$];
    int fails = 0, n_compared = 0, cyc = 0;
    wire [31:0] prdata;
    wire [7:0] cmdByte;
    wire pready, pslverr, converterEnableN, moduleClearN;
    wire cmdIsData, cmdValid, cmdReady, done;
    oled_power_init_sequencer #(.RESET_LOW_CYC(5), .RESET_WAIT_CYC(8),
        .ON_WAIT_CYC(10), .OFF_WAIT_CYC(6)) dut (
        .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .converterEnableN(converterEnableN), .moduleClearN(moduleClearN),
        .cmdByte(cmdByte), .cmdIsData(cmdIsData), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .done(done));
    oled_module_model model (.clock(clock), .moduleClearN(moduleClearN),
        .converterEnableN(converterEnableN), .cmdByte(cmdByte),
        .cmdIsData(cmdIsData), .cmdValid(cmdValid), .stall(stall),
        .cmdReady(cmdReady));
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always #5 clock = ~clock;
    // far side stalls at random only while a test asks for it
    always @(posedge clock) begin
        lfsr <= nextRand(lfsr);
        stall <= slow && lfsr[0];
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, ex);
        n_compared++;
        if (seen !== ex) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, ex, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask
    task automatic runInit(input logic byp, input logic slw);
        slow = slw;
        model.got.delete();
        apb(1, 8'h00, {29'h0, byp, 2'b01});
        while (done !== 1'b1) @(posedge clock);
        foreach (exp[i]) chk("byte", 32'(model.got[i]), 32'(exp[i]));
        chk("count", model.got.size(), exp.size());
        chk("conv at on", 32'(model.convAtOn), 32'(!byp));
        chk("mode", 32'({model.unlocked, model.fromMemory}), 3);
        apb(0, 8'h04, 0);
        chk("done bit", 32'(rd[9]), 1);
        $display("test init done");
    endtask
    task automatic powerOff();
        apb(1, 8'h00, 32'h2);
        do apb(0, 8'h04, 0); while (rd[11] !== 1'b1);
        chk("last byte", 32'(model.got[$]), 32'h0AE);
        chk("conv off", 32'({converterEnableN, done}), 0);
        $display("test off done");
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        foreach (INIT[i]) exp.push_back({1'b0, INIT[i]});
        for (int p = 0; p < 8; p++) begin
            exp.push_back(9'h0B0 + 9'(p));
            exp.push_back(9'h000);
            exp.push_back(9'h010);
            repeat (128) exp.push_back(9'h100);
        end
        exp.push_back(9'h0AF);
        repeat (16) @(posedge clock);
        rstn <= 1;
        @(posedge clock);
        chk("conv reset", 32'(converterEnableN), 0);
        apb(0, 8'h04, 0);
        chk("status", rd, 32'h801);
        apb(1, 8'h00, 32'h4);
        apb(0, 8'h00, 0);
        chk("bypass", 32'(rd[2]), 1);
        apb(0, 8'h08, 0);
        chk("unmapped", 32'(err), 1);
        $display("test registers done");
        runInit(0, 0);
        powerOff();
        runInit(1, 1);
        apb(1, 8'h00, 32'h1);
        repeat (30) @(posedge clock);
        rstn <= 0;
        repeat (2) @(posedge clock);
        rstn <= 1;
        @(posedge clock);
        chk("mid reset", 32'({moduleClearN, cmdValid, done}), 4);
        runInit(0, 1);
        powerOff();
        print_verdict();
    end
endmodule // oled_power_init_sequencer_tb

/* verification/oled_seq_properties.sv */
// port timing properties of the display power sequencer
module oled_seq_properties #(
    parameter RESET_LOW_CYC  = 5,
    parameter RESET_WAIT_CYC = 8,
    parameter ON_WAIT_CYC    = 10
) (
    input wire       clock,
    input wire       rstn,
    input wire       psel,
    input wire       penable,
    input wire [7:0] paddr,
    input wire       pready,
    input wire       pslverr,
    input wire       converterEnableN,
    input wire       moduleClearN,
    input wire [7:0] cmdByte,
    input wire       cmdIsData,
    input wire       cmdValid,
    input wire       cmdReady,
    input wire       done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lowCnt;
    logic [15:0] relCnt;
    logic [15:0] onCnt;
    wire take = cmdValid && cmdReady;
    // counters saturate so a long idle cannot wrap them
    always @(posedge clock) begin
        lowCnt <= (!rstn || moduleClearN) ? 16'h0
                  : lowCnt + {15'h0, ~&lowCnt};
        relCnt <= (!rstn || !moduleClearN) ? 16'h0
                  : relCnt + {15'h0, ~&relCnt};
        onCnt  <= (!rstn || (take && cmdByte == 8'hAF)) ? 16'h0
                  : onCnt + {15'h0, ~&onCnt};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_reset_pulse_len: assert property (
        $rose(moduleClearN) |-> lowCnt >= RESET_LOW_CYC) else $error("short");
    a_no_cmd_reset: assert property (
        !moduleClearN |-> !cmdValid) else $error("cmd in reset");
    a_first_cmd_wait: assert property (
        cmdValid |-> relCnt >= RESET_WAIT_CYC) else $error("early cmd");
    a_cmd_held: assert property (
        cmdValid && !cmdReady |=> cmdValid && $stable({cmdIsData, cmdByte}))
        else $error("cmd dropped");
    a_conv_on_at_af: assert property (
        $rose(converterEnableN) |-> cmdValid && !cmdIsData
        && cmdByte == 8'hAF) else $error("converter early");
    a_conv_off_ae: assert property (
        $fell(converterEnableN) && $past(rstn) |-> $past(take)
        && $past(cmdByte) == 8'hAE) else $error("converter off early");
    a_done_after_wait: assert property (
        $rose(done) |-> onCnt >= ON_WAIT_CYC) else $error("early done");
    a_apb_answer: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("no answer");
    a_apb_error_addr: assert property (
        pready |-> pslverr == (paddr != 8'h00 && paddr != 8'h04))
        else $error("bad error");
endmodule // oled_seq_properties

// defaults match the short timings that the bench gives the design
bind oled_power_init_sequencer oled_seq_properties props (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .converterEnableN(converterEnableN), .moduleClearN(moduleClearN),
    .cmdByte(cmdByte), .cmdIsData(cmdIsData), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .done(done));
